//--- rtl/sync_line_pkg.sv
// Constants, register layout and carrier types of the synchronous line register bank.
// Assumes a 50 MHz system clock shared by the register port and the line logic.
package sync_line_pkg;
   localparam longint CLK_HZ = 50_000_000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int DMA_TIMEOUT_NS = 32000;
   localparam int DMA_TIMEOUT_CYCLES = (DMA_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [3:0] REG_TX_ERR_BAUD = 4'h2;
   localparam logic [3:0] REG_SYNC_CHAR_COUNT = 4'h3;
   localparam logic [3:0] REG_MODEM_LINES = 4'h4;
   localparam logic [3:0] REG_STATION_ADDR = 4'h5;
   localparam logic [3:0] REG_RX_ADDR_LOW = 4'h6;
   localparam logic [3:0] REG_RX_ADDR_HIGH_COUNT = 4'h7;

   localparam int LEN_VIOLATION_BIT = 0;
   localparam int DMA_ERR_BIT = 1;
   localparam int UNDERRUN_BIT = 2;
   localparam int BAUD_LSB = 8;
   localparam int SYNC_COUNT_LSB = 0;
   localparam int SYNC_CHAR_LSB = 8;
   localparam int USER_RX_BIT = 2;
   localparam int CTS_BIT = 4;
   localparam int DCD_BIT = 5;
   localparam int RING_BIT = 6;
   localparam int DSR_BIT = 7;
   localparam int USER_TX_BIT = 8;
   localparam int DTR_BIT = 9;
   localparam int RATE_SEL_BIT = 10;
   localparam int RTS_BIT = 12;
   localparam int ADDR_HIGH_LSB = 14;
   localparam int RX_COUNT_LSB = 0;

   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [13:0] BIT_MIN_MSG_LEN = 14'h0004;
   localparam logic [13:0] BYTE_MIN_MSG_LEN = 14'h0001;
   localparam logic [7:0] IDLE_ONES = 8'hff;

   // Line rates in millibits per second, indexed by the 4-bit rate code.
   localparam longint BAUD_MILLIBPS [0:15] = '{
      800000, 1200000, 1760000, 2152357, 2400000, 4800000, 9600000, 19200000,
      28800000, 32081013, 38400000, 57600000, 76800000, 115200000, 153600000, 316800000};

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } regReq_type;

   typedef struct packed {
      logic userRx;
      logic clearToSend;
      logic carrierDetect;
      logic ringIndicator;
      logic dataSetReady;
   } modemIn_type;

   typedef struct packed {
      logic userTx;
      logic termReady;
      logic rateSelect;
      logic requestToSend;
   } modemOut_type;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_PREAMBLE = 2'b01,
      TX_MESSAGE = 2'b10
   } txState_type;
endpackage

//--- rtl/sync_line_indirect_regs.sv
// Register bank of the synchronous line: transmit errors and rate, sync character, modem
// lines, station address and primary receive buffer, plus the small logic they steer.
// Assumes all inputs synchronous to clk; busInit is a synchronous one-cycle-or-longer level.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Flag length violation before sending when count is below protocol minimum.
// - Length violation clears only on master reset or transmit error read.
// - Flag transmit DMA error after 32 us without slave response or grant.
// - DMA error and underrun clear on reset, bus initialize or error read.
// - Flag transmit underrun when outgoing data is not ready in time.
// - Transmit bit rate comes from a sixteen-entry table indexed by bits 11:8.
// - Bits 15:12 of the error and rate register clear on reset or initialize.
// - Send the sync character count times before every message in byte protocols.
// - Byte protocols with idle select clear send sync fill between messages.
// - On underrun, send one sync character, then idle fill as the error ends the message.
// - Receiver uses the sync character to gain character synchronization.
// - Modem input lines read live at bits 2, 4, 5, 6, 7.
// - Any modem input transition sets the data set change flag.
// - Modem outputs follow bits 8, 9, 10, 12; set means ON.
// - Compare station address with each incoming message address field.
// - One-byte addresses compare only the low byte.
// - Receive buffer address is 16 low bits plus bits 15:14 above.
// - Software loads count; device decrements per DMA transfer; readable back.
// - Excess bytes beyond the buffer are discarded and, outside general byte mode, flagged as overflow.
// - Writing the receive count clears receiver done.
// - Overflow sets at zero count with bytes left, never in general byte mode.
// - Summary error is OR of error flags and clears transmit enable.
module sync_line_indirect_regs #(
   parameter int unsigned BAUD_DIV_SHIFT = 0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic busInit,
   input wire sync_line_pkg::regReq_type regReq,
   output logic [15:0] regRdata,
   input wire logic masterSyncStrobe,
   input wire logic slaveSyncResponse,
   input wire logic dmaBusRequest,
   input wire logic dmaBusGrant,
   input wire logic bitOriented,
   input wire logic generalByteMode,
   input wire logic idleSelect,
   input wire logic txMsgStart,
   input wire logic [13:0] txMsgLen,
   input wire logic txCharReq,
   input wire logic txDataValid,
   input wire logic txDataLast,
   input wire logic [7:0] txData,
   output logic txDataTake,
   output logic [7:0] txChar,
   output logic txCharValid,
   output logic txBitTick,
   output logic txErrSummary,
   output logic txEnableClr,
   input wire sync_line_pkg::modemIn_type modemIn,
   output sync_line_pkg::modemOut_type modemOut,
   output logic dataSetChange,
   input wire logic rxHunt,
   input wire logic rxCharValid,
   input wire logic [7:0] rxChar,
   output logic rxSynced,
   input wire logic rxAddrValid,
   input wire logic [15:0] rxAddr,
   input wire logic oneByteAddr,
   output logic addrMatchValid,
   output logic addrMatch,
   output logic [17:0] rxBufAddr,
   input wire logic rxByteXfer,
   input wire logic rxOverflowClr,
   output logic rxWriteOk,
   output logic rxDiscard,
   output logic rxOverflow,
   output logic rxDoneClr
);
   logic lenViol_q, lenViol_d, dmaErr_q, dmaErr_d, underrun_q, underrun_d;
   logic [3:0] baudCode_q;
   logic [7:0] syncCount_q, syncChar_q, preambleLeft_q;
   sync_line_pkg::modemIn_type modemIn_q, modemPrev_q;
   logic [15:0] stationAddr_q, rxAddrLow_q, rdMux;
   logic [1:0] rxAddrHigh_q;
   logic [13:0] rxCount_q;
   logic [16:0] tickCnt_q;
   logic [16:0] divTable [0:15];
   logic [10:0] waitCnt_q [0:1];
   logic [1:0] waiting, timedOut;
   sync_line_pkg::txState_type txState_q;
   logic wrEn, rdTxErr, wrCount, underrunEvt, lenViolEvt, minOk;

   assign wrEn = clkEn && regReq.wr;
   assign rdTxErr = clkEn && regReq.rd && regReq.addr == sync_line_pkg::REG_TX_ERR_BAUD;
   assign wrCount = wrEn && regReq.addr == sync_line_pkg::REG_RX_ADDR_HIGH_COUNT;

   // Register writes. Only the documented fields are stored, so other bits ignore writes.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         baudCode_q <= 4'h0;
         syncCount_q <= 8'h00;
         syncChar_q <= 8'h00;
         modemOut <= '0;
         stationAddr_q <= sync_line_pkg::REG_RESET;
         rxAddrLow_q <= sync_line_pkg::REG_RESET;
         rxAddrHigh_q <= 2'h0;
      end else if (wrEn) begin
         unique case (regReq.addr)
            sync_line_pkg::REG_TX_ERR_BAUD: begin
               baudCode_q <= regReq.wdata[sync_line_pkg::BAUD_LSB +: 4];
            end
            sync_line_pkg::REG_SYNC_CHAR_COUNT: begin
               syncCount_q <= regReq.wdata[sync_line_pkg::SYNC_COUNT_LSB +: 8];
               syncChar_q <= regReq.wdata[sync_line_pkg::SYNC_CHAR_LSB +: 8];
            end
            sync_line_pkg::REG_MODEM_LINES: begin
               modemOut.userTx <= regReq.wdata[sync_line_pkg::USER_TX_BIT];
               modemOut.termReady <= regReq.wdata[sync_line_pkg::DTR_BIT];
               modemOut.rateSelect <= regReq.wdata[sync_line_pkg::RATE_SEL_BIT];
               modemOut.requestToSend <= regReq.wdata[sync_line_pkg::RTS_BIT];
            end
            sync_line_pkg::REG_STATION_ADDR: stationAddr_q <= regReq.wdata;
            sync_line_pkg::REG_RX_ADDR_LOW: rxAddrLow_q <= regReq.wdata;
            sync_line_pkg::REG_RX_ADDR_HIGH_COUNT: begin
               rxAddrHigh_q <= regReq.wdata[sync_line_pkg::ADDR_HIGH_LSB +: 2];
            end
            default: begin
            end
         endcase
      end
   end

   // Read mux. Bits 15:12 of the error and rate register hold no storage and read zero,
   // which is also their value after reset or initialize.
   always_comb begin
      rdMux = 16'h0000;
      unique case (regReq.addr)
         sync_line_pkg::REG_TX_ERR_BAUD: begin
            rdMux[sync_line_pkg::LEN_VIOLATION_BIT] = lenViol_q;
            rdMux[sync_line_pkg::DMA_ERR_BIT] = dmaErr_q;
            rdMux[sync_line_pkg::UNDERRUN_BIT] = underrun_q;
            rdMux[sync_line_pkg::BAUD_LSB +: 4] = baudCode_q;
         end
         sync_line_pkg::REG_SYNC_CHAR_COUNT: rdMux = {syncChar_q, syncCount_q};
         sync_line_pkg::REG_MODEM_LINES: begin
            rdMux[sync_line_pkg::USER_RX_BIT] = modemIn_q.userRx;
            rdMux[sync_line_pkg::CTS_BIT] = modemIn_q.clearToSend;
            rdMux[sync_line_pkg::DCD_BIT] = modemIn_q.carrierDetect;
            rdMux[sync_line_pkg::RING_BIT] = modemIn_q.ringIndicator;
            rdMux[sync_line_pkg::DSR_BIT] = modemIn_q.dataSetReady;
            rdMux[sync_line_pkg::USER_TX_BIT] = modemOut.userTx;
            rdMux[sync_line_pkg::DTR_BIT] = modemOut.termReady;
            rdMux[sync_line_pkg::RATE_SEL_BIT] = modemOut.rateSelect;
            rdMux[sync_line_pkg::RTS_BIT] = modemOut.requestToSend;
         end
         sync_line_pkg::REG_STATION_ADDR: rdMux = stationAddr_q;
         sync_line_pkg::REG_RX_ADDR_LOW: rdMux = rxAddrLow_q;
         sync_line_pkg::REG_RX_ADDR_HIGH_COUNT: rdMux = {rxAddrHigh_q, rxCount_q};
         default: rdMux = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= 16'h0000;
      end else if (clkEn) begin
         regRdata <= regReq.rd ? rdMux : 16'h0000;
      end
   end

   // Bus watchdogs: one for slave response after master sync, one for mastership grant.
   assign waiting[0] = masterSyncStrobe && !slaveSyncResponse;
   assign waiting[1] = dmaBusRequest && !dmaBusGrant;
   for (genvar g = 0; g < 2; g++) begin : gWatch
      assign timedOut[g] = waiting[g] && waitCnt_q[g] == 11'(sync_line_pkg::DMA_TIMEOUT_CYCLES - 1);
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            waitCnt_q[g] <= 11'h000;
         end else if (clkEn) begin
            if (!waiting[g]) begin
               waitCnt_q[g] <= 11'h000;
            end else if (!timedOut[g]) begin
               waitCnt_q[g] <= waitCnt_q[g] + 11'h001;
            end
         end
      end
   end

   // Error flags: a new event wins over a clear in the same cycle.
   assign minOk = txMsgLen >= (bitOriented ? sync_line_pkg::BIT_MIN_MSG_LEN : sync_line_pkg::BYTE_MIN_MSG_LEN);
   assign lenViolEvt = txMsgStart && !minOk;
   assign underrunEvt = txCharReq && txState_q == sync_line_pkg::TX_MESSAGE && !txDataValid;
   always_comb begin
      lenViol_d = lenViol_q && !rdTxErr;
      dmaErr_d = dmaErr_q && !rdTxErr && !busInit;
      underrun_d = underrun_q && !rdTxErr && !busInit;
      if (lenViolEvt) begin
         lenViol_d = 1'b1;
      end
      if (|timedOut) begin
         dmaErr_d = 1'b1;
      end
      if (underrunEvt) begin
         underrun_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lenViol_q <= 1'b0;
         dmaErr_q <= 1'b0;
         underrun_q <= 1'b0;
         txErrSummary <= 1'b0;
         txEnableClr <= 1'b0;
      end else if (clkEn) begin
         lenViol_q <= lenViol_d;
         dmaErr_q <= dmaErr_d;
         underrun_q <= underrun_d;
         txErrSummary <= lenViol_d || dmaErr_d || underrun_d;
         txEnableClr <= (lenViol_d || dmaErr_d || underrun_d) && !txErrSummary;
      end
   end

   // Transmit rate generator; the shift lets a simulation shorten the long divisors.
   for (genvar g = 0; g < 16; g++) begin : gBaud
      localparam logic [16:0] DIV_RAW = 17'((sync_line_pkg::CLK_HZ * 1000 +
         sync_line_pkg::BAUD_MILLIBPS[g] / 2) / sync_line_pkg::BAUD_MILLIBPS[g]);
      localparam logic [16:0] DIV_SH = DIV_RAW >> BAUD_DIV_SHIFT;
      assign divTable[g] = (DIV_SH == 17'h0_0000) ? 17'h0_0001 : DIV_SH;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tickCnt_q <= 17'h0_0000;
         txBitTick <= 1'b0;
      end else if (clkEn) begin
         txBitTick <= tickCnt_q == 17'h0_0000;
         if (tickCnt_q == 17'h0_0000) begin
            tickCnt_q <= divTable[baudCode_q] - 17'h0_0001;
         end else begin
            tickCnt_q <= tickCnt_q - 17'h0_0001;
         end
      end
   end

   // Transmit character source: preamble syncs, message data, then idle fill.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txState_q <= sync_line_pkg::TX_IDLE;
         preambleLeft_q <= 8'h00;
         txChar <= sync_line_pkg::IDLE_ONES;
         txCharValid <= 1'b0;
         txDataTake <= 1'b0;
      end else if (clkEn) begin
         txCharValid <= txCharReq;
         txDataTake <= 1'b0;
         if (txErrSummary && txState_q != sync_line_pkg::TX_IDLE) begin
            txState_q <= sync_line_pkg::TX_IDLE;
         end else if (txMsgStart && txState_q == sync_line_pkg::TX_IDLE && minOk) begin
            preambleLeft_q <= syncCount_q;
            txState_q <= (syncCount_q != 8'h00 && !bitOriented) ? sync_line_pkg::TX_PREAMBLE
                                                                : sync_line_pkg::TX_MESSAGE;
         end else if (txCharReq) begin
            unique case (txState_q)
               sync_line_pkg::TX_IDLE: begin
                  txChar <= (!idleSelect && !bitOriented) ? syncChar_q : sync_line_pkg::IDLE_ONES;
               end
               sync_line_pkg::TX_PREAMBLE: begin
                  txChar <= syncChar_q;
                  preambleLeft_q <= preambleLeft_q - 8'h01;
                  if (preambleLeft_q == 8'h01) begin
                     txState_q <= sync_line_pkg::TX_MESSAGE;
                  end
               end
               sync_line_pkg::TX_MESSAGE: begin
                  if (txDataValid) begin
                     txChar <= txData;
                     txDataTake <= 1'b1;
                     if (txDataLast) begin
                        txState_q <= sync_line_pkg::TX_IDLE;
                     end
                  end else begin
                     txChar <= syncChar_q;
                  end
               end
               default: txState_q <= sync_line_pkg::TX_IDLE;
            endcase
         end
      end
   end

   // Modem inputs are sampled once so the read value and the change flag agree.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         modemIn_q <= '0;
         modemPrev_q <= '0;
         dataSetChange <= 1'b0;
      end else if (clkEn) begin
         modemIn_q <= modemIn;
         modemPrev_q <= modemIn_q;
         dataSetChange <= |(modemIn_q ^ modemPrev_q);
      end
   end

   // Receive side: sync hunt, address filter and primary buffer count.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxSynced <= 1'b0;
         addrMatchValid <= 1'b0;
         addrMatch <= 1'b0;
      end else if (clkEn) begin
         if (!rxHunt) begin
            rxSynced <= 1'b0;
         end else if (rxCharValid && !bitOriented && rxChar == syncChar_q) begin
            rxSynced <= 1'b1;
         end
         addrMatchValid <= rxAddrValid;
         if (rxAddrValid) begin
            addrMatch <= oneByteAddr ? rxAddr[7:0] == stationAddr_q[7:0]
                                     : rxAddr == stationAddr_q;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxCount_q <= 14'h0000;
         rxWriteOk <= 1'b0;
         rxDiscard <= 1'b0;
         rxOverflow <= 1'b0;
         rxDoneClr <= 1'b0;
         rxBufAddr <= 18'h0_0000;
      end else if (clkEn) begin
         rxBufAddr <= {rxAddrHigh_q, rxAddrLow_q};
         rxDoneClr <= wrCount;
         rxWriteOk <= rxByteXfer && rxCount_q != 14'h0000 && !wrCount;
         rxDiscard <= rxByteXfer && (rxCount_q == 14'h0000 || wrCount);
         if (wrCount) begin
            rxCount_q <= regReq.wdata[sync_line_pkg::RX_COUNT_LSB +: 14];
         end else if (rxByteXfer && rxCount_q != 14'h0000) begin
            rxCount_q <= rxCount_q - 14'h0001;
         end
         if (rxByteXfer && rxCount_q == 14'h0000 && !wrCount && !generalByteMode) begin
            rxOverflow <= 1'b1;
         end else if (rxOverflowClr) begin
            rxOverflow <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_LEN_VIOL_SET: assert property (clkEn && txMsgStart && bitOriented && txMsgLen < 14'h0004 |=> lenViol_q)
      else $error("length violation not flagged");
   AST_LEN_VIOL_KEEP: assert property (lenViol_q && !rdTxErr |=> lenViol_q)
      else $error("length violation cleared without a read");
   AST_DMA_TIMEOUT: assert property (clkEn && waiting[0]
      && waitCnt_q[0] == 11'(sync_line_pkg::DMA_TIMEOUT_CYCLES - 1) |=> dmaErr_q)
      else $error("bus response timeout not flagged");
   AST_INIT_CLEAR: assert property (clkEn && busInit && !underrunEvt && !(|timedOut)
      |=> !underrun_q && !dmaErr_q)
      else $error("initialize did not clear errors");
   AST_UNDERRUN_FILL: assert property (clkEn && underrunEvt && !txErrSummary && !txMsgStart
      |=> underrun_q && txCharValid && txChar == syncChar_q)
      else $error("underrun not flagged or filled");
   AST_PREAMBLE_SYNC: assert property (clkEn && txCharReq && txState_q == sync_line_pkg::TX_PREAMBLE
      && !txErrSummary |=> txChar == syncChar_q)
      else $error("preamble character is not sync");
   AST_MODEM_CHANGE: assert property ((clkEn && modemIn != modemIn_q) ##1 clkEn |=> dataSetChange)
      else $error("modem transition missed");
   AST_RX_OVERFLOW: assert property (clkEn && rxByteXfer && rxCount_q == 14'h0000 && !wrCount
      && !generalByteMode |=> rxOverflow && rxDiscard && !rxWriteOk)
      else $error("overflow not reported");
   AST_SUMMARY_CLR: assert property ($rose(txErrSummary) |-> txEnableClr)
      else $error("enable clear missing on error");
   AST_COUNT_LOAD: assert property (wrCount |=> rxDoneClr && rxCount_q == $past(regReq.wdata[13:0]))
      else $error("count load misbehaved");
   AST_UNMAPPED_ZERO: assert property (clkEn && regReq.rd && (regReq.addr < 4'h2 || regReq.addr > 4'h7)
      |=> regRdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule // sync_line_indirect_regs

`default_nettype wire

//--- verif/sync_line_far_end.sv
// Far-side model of the transmit DMA source that offers message bytes A0, A1, A2.
// Assumes txDataTake pulses once for each byte the block consumed.
`timescale 1ns/1ps
`default_nettype none
module sync_line_far_end (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic txDataTake,
   output logic txDataValid,
   output logic txDataLast,
   output logic [7:0] txData
);
   logic [1:0] idx_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_q <= 2'h0;
      end else if (txDataTake) begin
         idx_q <= idx_q + 2'h1;
      end
   end
   // A stalled source drives the inverted byte, so it shows no stale byte.
   assign txDataValid = !stall;
   assign txData = stall ? ~(8'ha0 + 8'(idx_q)) : 8'ha0 + 8'(idx_q);
   assign txDataLast = !stall && idx_q == 2'h2;
endmodule // sync_line_far_end
`default_nettype wire

//--- verif/sync_line_indirect_regs_bench.sv
// Self-checking bench of the synchronous line register bank.
// Assumes the far-side byte source model and a 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module sync_line_indirect_regs_bench;
   logic clk = 0, rst_n = 0, busInit = 0, msync = 0, bitOriented = 0, genByte = 0, txMsgStart = 0;
   logic txCharReq = 0, stall = 0, rxAddrValid = 0, oneByteAddr = 0, rxByteXfer = 0, ovfClr = 0;
   logic [13:0] txMsgLen = 14'h0;
   logic [15:0] rxAddr = 16'h0, regRdata;
   sync_line_pkg::regReq_type regReq = '0;
   sync_line_pkg::modemIn_type modemIn = '0;
   sync_line_pkg::modemOut_type modemOut;
   logic dv, dl, take, cv, sum, dsc, amv, am, wok, disc, ovf, doneClr;
   logic [7:0] td, txChar;
   logic [17:0] rxBufAddr;
   int mismatches = 0, numChecks = 0;
   logic clkEn = 1, idleSel = 0, hunt = 0, rxCv = 0, bitTick, enClr, synced;
   logic [7:0] rxCh = 8'h00;
   always #10 clk = ~clk;
   sync_line_far_end far_u (.clk(clk), .rst_n(rst_n), .stall(stall), .txDataTake(take), .txDataValid(dv),
      .txDataLast(dl), .txData(td));
   sync_line_indirect_regs #(.BAUD_DIV_SHIFT(8)) dut_u (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
      .busInit(busInit), .regReq(regReq), .regRdata(regRdata), .masterSyncStrobe(msync),
      .slaveSyncResponse(1'b0), .dmaBusRequest(1'b0), .dmaBusGrant(1'b0), .bitOriented(bitOriented),
      .generalByteMode(genByte), .idleSelect(idleSel), .txMsgStart(txMsgStart), .txMsgLen(txMsgLen),
      .txCharReq(txCharReq), .txDataValid(dv), .txDataLast(dl), .txData(td), .txDataTake(take),
      .txChar(txChar), .txCharValid(cv), .txBitTick(bitTick), .txErrSummary(sum), .txEnableClr(enClr),
      .modemIn(modemIn), .modemOut(modemOut), .dataSetChange(dsc), .rxHunt(hunt), .rxCharValid(rxCv),
      .rxChar(rxCh), .rxSynced(synced), .rxAddrValid(rxAddrValid), .rxAddr(rxAddr), .oneByteAddr(oneByteAddr),
      .addrMatchValid(amv), .addrMatch(am), .rxBufAddr(rxBufAddr), .rxByteXfer(rxByteXfer),
      .rxOverflowClr(ovfClr), .rxWriteOk(wok), .rxDiscard(disc), .rxOverflow(ovf), .rxDoneClr(doneClr));
   task automatic close_out();
      if (mismatches == 0 && numChecks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk) regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk) regReq.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk) regReq <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk) regReq.rd <= 1'b0;
      #1 chk(regRdata, exp);
   endtask
   task automatic req(input logic [7:0] exp);
      @(posedge clk) txCharReq <= 1'b1;
      @(posedge clk) txCharReq <= 1'b0;
      #1 chk({cv, txChar}, {1'b1, exp});
   endtask
   task automatic start(input logic [13:0] len);
      @(posedge clk) begin
         txMsgStart <= 1'b1;
         txMsgLen <= len;
      end
      @(posedge clk) txMsgStart <= 1'b0;
   endtask
   task automatic addr(input logic [15:0] a, input logic ob, input logic exp);
      @(posedge clk) begin
         rxAddrValid <= 1'b1;
         rxAddr <= a;
         oneByteAddr <= ob;
      end
      @(posedge clk) rxAddrValid <= 1'b0;
      #1 chk({amv, am}, {1'b1, exp});
   endtask
   task automatic xfer(input logic ok);
      @(posedge clk) rxByteXfer <= 1'b1;
      @(posedge clk) rxByteXfer <= 1'b0;
      #1 chk({wok, disc}, {ok, !ok});
   endtask
   initial begin
      #(20 * 20000);
      mismatches++;
      close_out();
   end
   initial begin
      int n;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 9; a++) rd(4'(a), 16'h0000);
      wr(4'h2, 16'hf7ff);
      rd(4'h2, 16'h0700);
      // A 19,200 bps divisor of 2604, shortened by the shift of 8, gives a tick every 10 cycles.
      n = 0;
      do @(posedge clk) #1 n++; while (bitTick !== 1'b1 && n < 300);
      n = 0;
      do @(posedge clk) #1 n++; while (bitTick !== 1'b1 && n < 300);
      chk(n, 10);
      wr(4'h3, 16'h1602);
      rd(4'h3, 16'h1602);
      @(posedge clk) begin
         hunt <= 1'b1;
         rxCv <= 1'b1;
         rxCh <= 8'h15;
      end
      @(posedge clk) rxCh <= 8'h16;
      #1 chk(synced, 1'b0);
      @(posedge clk) rxCv <= 1'b0;
      #1 chk(synced, 1'b1);
      wr(4'h5, 16'h1234);
      rd(4'h5, 16'h1234);
      // A write while the clock enable is low must leave the register untouched.
      @(posedge clk) clkEn <= 1'b0;
      wr(4'h5, 16'hbeef);
      @(posedge clk) clkEn <= 1'b1;
      rd(4'h5, 16'h1234);
      wr(4'h6, 16'h5678);
      wr(4'h7, 16'hc002);
      chk(doneClr, 1'b1);
      rd(4'h7, 16'hc002);
      chk(rxBufAddr, 18'h3_5678);
      wr(4'h4, 16'hffff);
      chk(modemOut, 4'hf);
      @(posedge clk) modemIn <= '1;
      n = 0;
      while (dsc !== 1'b1 && n < 6) begin
         @(posedge clk) #1;
         n++;
      end
      chk(dsc, 1'b1);
      rd(4'h4, 16'h17f4);
      wr(4'h4, 16'h0000);
      chk(modemOut, 4'h0);
      addr(16'hab34, 1'b1, 1'b1);
      addr(16'hab34, 1'b0, 1'b0);
      addr(16'h1234, 1'b0, 1'b1);
      xfer(1'b1);
      xfer(1'b1);
      xfer(1'b0);
      chk(ovf, 1'b1);
      rd(4'h7, 16'hc000);
      // A count of one byte in general byte mode must drop the excess silently.
      @(posedge clk) begin
         genByte <= 1'b1;
         ovfClr <= 1'b1;
      end
      @(posedge clk) ovfClr <= 1'b0;
      wr(4'h7, 16'h0001);
      xfer(1'b1);
      xfer(1'b0);
      chk(ovf, 1'b0);
      @(posedge clk) bitOriented <= 1'b1;
      start(14'h3);
      rd(4'h2, 16'h0701);
      rd(4'h2, 16'h0700);
      start(14'h3);
      @(posedge clk) busInit <= 1'b1;
      @(posedge clk) busInit <= 1'b0;
      rd(4'h2, 16'h0701);
      rd(4'h2, 16'h0700);
      @(posedge clk) bitOriented <= 1'b0;
      start(14'h3);
      req(8'h16);
      req(8'h16);
      req(8'ha0);
      chk(take, 1'b1);
      @(posedge clk) stall <= 1'b1;
      req(8'h16);
      chk(enClr, 1'b1);
      @(posedge clk) #1 chk(sum, 1'b1);
      rd(4'h2, 16'h0704);
      rd(4'h2, 16'h0700);
      req(8'h16);
      @(posedge clk) idleSel <= 1'b1;
      req(8'hff);
      @(posedge clk) msync <= 1'b1;
      repeat (1599) @(posedge clk);
      #1 chk(sum, 1'b0);
      @(posedge clk) #1 chk(sum, 1'b1);
      @(posedge clk) msync <= 1'b0;
      @(posedge clk) busInit <= 1'b1;
      @(posedge clk) busInit <= 1'b0;
      rd(4'h2, 16'h0700);
      close_out();
   end
endmodule // sync_line_indirect_regs_bench
`default_nettype wire
